// [itcg_pkg.sv]
// Operation
// - periodic interval interrupt usable for wake-up
// - single twelve-bit counter, three control registers
// - clock-enable register resets to zero
// - clock-enable register takes bit and byte writes
// - gate off: clock stopped, reset, writes refused, supply-control exempt
// - gate on: clock supplied, registers accessible
// - gate off: reads give reset values, supply-control exempt
// - gate off with subclock stops display clocks
// - low-power stop halts other peripherals in standby on the subclock
// - match clears counter and raises interrupt together
// - run bit starts; clearing stops and clears
// - period is count clock times compare plus one
// - clock select: zero subclock, one low-speed oscillator
package itcg_pkg;
    localparam logic [19:0] CLKEN_ADDR    = 20'hF00F0;  // peripheral clock-enable register
    localparam logic [19:0] SUPPLY_ADDR   = 20'hF00F3;  // subclock supply control register
    localparam logic [19:0] INTCTL_ADDR   = 20'hFFF90;  // interval control register
    localparam logic [7:0]  CLKEN_RESET   = 8'h00;      // clock-enable after reset
    localparam logic [7:0]  SUPPLY_RESET  = 8'h00;      // supply control after reset
    localparam logic [15:0] INTCTL_RESET  = 16'h0FFF;   // interval control after reset
    localparam int          GATE_BIT      = 7;          // clock-gate position in enable register
    localparam int          LPSTOP_BIT    = 7;          // low-power stop position in supply control
    localparam int          CLKSEL_BIT    = 4;          // clock select position in supply control
    localparam int          RUN_BIT       = 15;         // run position in interval control
    localparam logic [7:0]  SUPPLY_WMASK  = 8'h90;      // implemented supply-control bits
    localparam logic [15:0] INTCTL_WMASK  = 16'h8FFF;   // implemented interval-control bits
    localparam int          CNT_W         = 12;         // counter width
endpackage

// [itcg_top.sv]
`timescale 1ns/1ps
`default_nettype none
module itcg_top
    import itcg_pkg::*;
(
    input  wire logic        CLOCK_I,            // 200 MHz system clock
    input  wire logic        SYS_RST_I,          // synchronous reset, active high
    input  wire logic [19:0] ADDR_I,             // register address
    input  wire logic [15:0] WDATA_I,            // write data
    input  wire logic        WR_I,               // word/byte write strobe
    input  wire logic        RD_I,               // read strobe
    input  wire logic        BIT_WR_I,           // single-bit write strobe
    input  wire logic [2:0]  BIT_POS_I,          // bit position for single-bit write
    input  wire logic        BIT_VAL_I,          // value for single-bit write
    input  wire logic        HALT_I,             // chip in halt state
    input  wire logic        STOP_I,             // chip in stop state
    input  wire logic        SUB_CLK_I,          // subsystem clock pin (asynchronous)
    input  wire logic        LOSC_CLK_I,         // low-speed oscillator clock (asynchronous)
    output logic [15:0]      RDATA_O,            // read data, registered
    output logic             RVALID_O,           // read data valid pulse
    output logic             INTERVAL_INTERRUPT_O, // interval interrupt pulse
    output logic             RTC_CLK_EN_O,       // clock supply to rtc and timer
    output logic             RTC_RST_O,          // rtc and timer held in reset
    output logic             DISP_CLK_EN_O,      // display and clock-output clock supply
    output logic             PERIPH_STOP_O       // stop clocks of other peripherals
);
    // register state and timer state, all on the system clock
    logic [7:0]       peripheral_clock_enable_0; // peripheral clock-enable register
    logic [7:0]       subclock_supply_control;   // subclock supply control register
    logic             run_req;       // run bit as written
    logic             run_act;       // run bit as applied on a count edge
    logic [CNT_W-1:0] cmp;           // compare value
    logic [CNT_W-1:0] cnt;           // interval counter
    logic [2:0]       sub_s;         // subclock synchroniser plus edge stage
    logic [2:0]       losc_s;        // oscillator synchroniser plus edge stage
    logic             gate;          // clock gate
    logic             tick;          // one count-clock rising edge
    logic             sel_now;       // selected clock, synchronised
    logic             sel_old;       // selected clock, one cycle older
    logic             sub_sel;       // subsystem clock selected

    assign gate    = peripheral_clock_enable_0[GATE_BIT];
    assign sub_sel = ~subclock_supply_control[CLKSEL_BIT];
    // only the second and third stages are read; the first feeds the second alone
    assign sel_now = subclock_supply_control[CLKSEL_BIT] ? losc_s[1] : sub_s[1];
    assign sel_old = subclock_supply_control[CLKSEL_BIT] ? losc_s[2] : sub_s[2];
    // count edges only pass while the gate supplies the clock
    assign tick    = gate & sel_now & ~sel_old;

    // two-stage synchronisers for the slow count clocks
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            sub_s  <= 3'h0;
            losc_s <= 3'h0;
        end else begin
            sub_s  <= {sub_s[1:0], SUB_CLK_I};
            losc_s <= {losc_s[1:0], LOSC_CLK_I};
        end
    end

    // clock-enable register: byte and single-bit writes
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            peripheral_clock_enable_0 <= CLKEN_RESET;
        end else if (WR_I && ADDR_I == CLKEN_ADDR) begin
            peripheral_clock_enable_0 <= WDATA_I[7:0];
        end else if (BIT_WR_I && ADDR_I == CLKEN_ADDR) begin
            peripheral_clock_enable_0[BIT_POS_I] <= BIT_VAL_I;
        end
    end

    // supply control stays writable whatever the gate says
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            subclock_supply_control <= SUPPLY_RESET;
        end else if (WR_I && ADDR_I == SUPPLY_ADDR) begin
            // unimplemented bits stay zero so reads match the reset pattern
            subclock_supply_control <= WDATA_I[7:0] & SUPPLY_WMASK;
        end else if (BIT_WR_I && ADDR_I == SUPPLY_ADDR && SUPPLY_WMASK[BIT_POS_I]) begin
            subclock_supply_control[BIT_POS_I] <= BIT_VAL_I;
        end
    end

    // interval control: held at reset value while the gate is off
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I || !gate) begin
            run_req <= INTCTL_RESET[RUN_BIT];
            cmp     <= INTCTL_RESET[CNT_W-1:0];
        end else if (WR_I && ADDR_I == INTCTL_ADDR) begin
            run_req <= WDATA_I[RUN_BIT];
            cmp     <= WDATA_I[CNT_W-1:0];
        end
    end

    // run bit takes effect on the next count edge, so it reads back late
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I || !gate) begin
            run_act <= 1'b0;
        end else if (tick) begin
            run_act <= run_req;
        end
    end

    // twelve-bit counter; stopping also clears it
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I || !gate || !run_req) begin
            cnt <= '0;
        end else if (tick && run_act) begin
            if (cnt == cmp) begin
                cnt <= '0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    // interrupt pulses in the same cycle the counter wraps
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            INTERVAL_INTERRUPT_O <= 1'b0;
        end else begin
            INTERVAL_INTERRUPT_O <= gate & run_req & tick & run_act & (cnt == cmp);
        end
    end

    // clock supply and reset outputs for the gated units
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            RTC_CLK_EN_O  <= 1'b0;
            RTC_RST_O     <= 1'b1;
            DISP_CLK_EN_O <= 1'b0;
            PERIPH_STOP_O <= 1'b0;
        end else begin
            RTC_CLK_EN_O  <= gate;
            RTC_RST_O     <= ~gate;
            // with the low-speed oscillator selected the display side keeps running
            DISP_CLK_EN_O <= gate | ~sub_sel;
            PERIPH_STOP_O <= subclock_supply_control[LPSTOP_BIT] & sub_sel
                             & (HALT_I | STOP_I);
        end
    end

    // read port; unmapped addresses read zero
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            RDATA_O  <= 16'h0000;
            RVALID_O <= 1'b0;
        end else begin
            RVALID_O <= RD_I;
            if (!RD_I) begin
                RDATA_O <= 16'h0000;
            end else if (ADDR_I == CLKEN_ADDR) begin
                RDATA_O <= {8'h00, peripheral_clock_enable_0};
            end else if (ADDR_I == SUPPLY_ADDR) begin
                RDATA_O <= {8'h00, subclock_supply_control};
            end else if (ADDR_I == INTCTL_ADDR) begin
                if (gate) begin
                    RDATA_O <= {run_act, 3'h0, cmp};
                end else begin
                    // the fields are cleared one cycle after the gate drops,
                    // so the read path forces the reset pattern itself
                    RDATA_O <= INTCTL_RESET & INTCTL_WMASK;
                end
            end else begin
                RDATA_O <= 16'h0000;
            end
        end
    end

    // gate and reset behaviour of the supplied units
    a_gate_resets: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        !gate |=> (cnt == '0) && !run_act && RTC_RST_O && !RTC_CLK_EN_O)
        else $error("gate off did not hold timer in reset");
    a_gate_on_clock: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        gate |=> RTC_CLK_EN_O && !RTC_RST_O)
        else $error("gate on did not supply clock");
    a_gated_write: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (!gate && WR_I && ADDR_I == INTCTL_ADDR) |=>
            run_req == INTCTL_RESET[RUN_BIT] && cmp == INTCTL_RESET[CNT_W-1:0])
        else $error("interval control write taken with gate off");
    // register port, display clock and standby stop
    a_intctl_refused: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (!gate && RD_I && ADDR_I == INTCTL_ADDR) |=> RDATA_O == INTCTL_RESET)
        else $error("interval control read not reset value with gate off");
    a_read_answer: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        RD_I |=> RVALID_O)
        else $error("read not answered in one cycle");
    a_bit_write: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (BIT_WR_I && !WR_I && ADDR_I == CLKEN_ADDR) |=>
            peripheral_clock_enable_0[$past(BIT_POS_I)] == $past(BIT_VAL_I))
        else $error("single-bit write did not land");
    a_disp_clock: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (!gate && !subclock_supply_control[CLKSEL_BIT]) |=> !DISP_CLK_EN_O)
        else $error("display clock not stopped");
    a_lp_stop: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (subclock_supply_control[LPSTOP_BIT] && sub_sel && STOP_I) |=> PERIPH_STOP_O)
        else $error("peripheral clocks not stopped in standby");
    // counter and interrupt, enable-register reset
    a_match_wrap: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (gate && run_req && tick && run_act && cnt == cmp) |=> cnt == '0 && INTERVAL_INTERRUPT_O)
        else $error("match did not wrap with interrupt");
    a_irq_cause: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        INTERVAL_INTERRUPT_O |-> $past(cnt) == $past(cmp) && $past(tick))
        else $error("interrupt without match");
    a_stop_clears: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        !run_req |=> cnt == '0)
        else $error("counter not cleared while stopped");
    a_count_step: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (gate && run_req && run_act && tick && cnt != cmp) |=> cnt == $past(cnt) + 1'b1)
        else $error("counter did not advance on count edge");
    a_no_tick_hold: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (!tick && run_req && gate) |=> $stable(cnt))
        else $error("counter moved without count edge");
    a_clken_reset: assert property (@(posedge CLOCK_I)
        SYS_RST_I |=> peripheral_clock_enable_0 == CLKEN_RESET)
        else $error("enable register not cleared by reset");

    // scenarios worth seeing
    c_irq:      cover property (@(posedge CLOCK_I) INTERVAL_INTERRUPT_O);
    c_losc_run: cover property (@(posedge CLOCK_I)
        subclock_supply_control[CLKSEL_BIT] && run_act && tick);
    c_stop:     cover property (@(posedge CLOCK_I) PERIPH_STOP_O);
    c_gate_off: cover property (@(posedge CLOCK_I) run_act ##1 !gate);
endmodule
`default_nettype wire

// [itcg_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
module itcg_top_test;
    import itcg_pkg::*;
    logic        CLOCK_I = 1'b0, SYS_RST_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;  // clock, reset, strobes
    logic        BIT_WR_I = 1'b0, BIT_VAL_I = 1'b0, HALT_I = 1'b0, STOP_I = 1'b0;  // bit write, standby
    logic        SUB_CLK_I = 1'b0, LOSC_CLK_I = 1'b0;  // slow count clocks
    logic [19:0] ADDR_I = 20'h00000;  // register address
    logic [15:0] WDATA_I = 16'h0000;  // write data
    logic [2:0]  BIT_POS_I = 3'h0;    // bit index
    logic [15:0] RDATA_O;             // read data
    logic        RVALID_O, INTERVAL_INTERRUPT_O, RTC_CLK_EN_O, RTC_RST_O, DISP_CLK_EN_O, PERIPH_STOP_O;
    int          n_errors = 0, n_checks = 0, gap, k;  // counters and measurements

    itcg_top i_itcg_top (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .BIT_WR_I(BIT_WR_I), .BIT_POS_I(BIT_POS_I),
        .BIT_VAL_I(BIT_VAL_I), .HALT_I(HALT_I), .STOP_I(STOP_I), .SUB_CLK_I(SUB_CLK_I),
        .LOSC_CLK_I(LOSC_CLK_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
        .INTERVAL_INTERRUPT_O(INTERVAL_INTERRUPT_O), .RTC_CLK_EN_O(RTC_CLK_EN_O),
        .RTC_RST_O(RTC_RST_O), .DISP_CLK_EN_O(DISP_CLK_EN_O), .PERIPH_STOP_O(PERIPH_STOP_O));

    // system clock, 5 ns period
    initial begin
        forever #2.5 CLOCK_I = ~CLOCK_I;
    end
    // subclock 40 ns (8 cycles) and oscillator 60 ns (12 cycles), offset off the system edges
    initial begin
        #3;
        forever #20 SUB_CLK_I = ~SUB_CLK_I;
    end
    initial begin
        #7;
        forever #30 LOSC_CLK_I = ~LOSC_CLK_I;
    end
    // one compare for every kind of result; an unknown never matches
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // word write: strobe held for exactly one taking edge
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge CLOCK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CLOCK_I);
        WR_I <= 1'b0;
    endtask
    // single-bit write
    task automatic bw(input logic [2:0] p, input logic v);
        @(posedge CLOCK_I);
        ADDR_I <= CLKEN_ADDR;
        BIT_POS_I <= p;
        BIT_VAL_I <= v;
        BIT_WR_I <= 1'b1;
        @(posedge CLOCK_I);
        BIT_WR_I <= 1'b0;
    endtask
    // read: answer stands from the taking edge and is sampled 1 ns later; no valid gives unknown
    task automatic rd(input logic [19:0] a, input logic [15:0] exp, input string nm);
        @(posedge CLOCK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CLOCK_I);
        RD_I <= 1'b0;
        #1 chk(nm, exp, RVALID_O ? RDATA_O : 16'hXXXX);
    endtask
    // let registered outputs follow a write
    task automatic settle;
        repeat (2) @(posedge CLOCK_I);
        #1;
    endtask
    // cycles between two interrupt pulses, bounded so a dead timer cannot hang
    task automatic irq_gap(output int n);
        n = 0;
        for (int i = 0; i < 400; i++) begin
            @(posedge CLOCK_I);
            #1;
            if (INTERVAL_INTERRUPT_O === 1'b1) break;
        end
        do begin
            @(posedge CLOCK_I);
            #1;
            n++;
        end while (INTERVAL_INTERRUPT_O !== 1'b1 && n < 400);
    endtask
    // pulses seen over 60 cycles
    task automatic quiet(output int c);
        c = 0;
        repeat (60) begin
            @(posedge CLOCK_I);
            #1;
            if (INTERVAL_INTERRUPT_O === 1'b1) c++;
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // a full run is a few hundred cycles; this is far beyond it
    initial begin
        #200000;
        n_errors++;
        results;
    end

    initial begin
        repeat (20) @(posedge CLOCK_I);
        SYS_RST_I <= 1'b0;
        settle;
        chk("rtc_rst", 16'h0001, 16'(RTC_RST_O));
        chk("rtc_clk_en", 16'h0000, 16'(RTC_CLK_EN_O));
        rd(CLKEN_ADDR, 16'h0000, "clken_reset");
        wr(INTCTL_ADDR, 16'h8005);
        rd(INTCTL_ADDR, 16'h0FFF, "intctl_gated");
        wr(SUPPLY_ADDR, 16'h0010);
        rd(SUPPLY_ADDR, 16'h0010, "supply_gated");
        chk("disp_clk_en", 16'h0001, 16'(DISP_CLK_EN_O));
        wr(SUPPLY_ADDR, 16'h0000);
        settle;
        chk("disp_clk_off", 16'h0000, 16'(DISP_CLK_EN_O));
        bw(3'(GATE_BIT), 1'b1);
        settle;
        chk("rtc_on", 16'h0002, {14'h0000, RTC_CLK_EN_O, RTC_RST_O});
        rd(CLKEN_ADDR, 16'h0080, "clken_bit");
        wr(INTCTL_ADDR, 16'h8001);
        irq_gap(gap);
        chk("gap_sub_1", 16'h0010, 16'(gap));
        rd(INTCTL_ADDR, 16'h8001, "intctl_run");
        wr(INTCTL_ADDR, 16'h0003);
        repeat (10) @(posedge CLOCK_I);
        quiet(k);
        chk("stopped", 16'h0000, 16'(k));
        rd(INTCTL_ADDR, 16'h0003, "intctl_stop");
        wr(INTCTL_ADDR, 16'h8003);
        irq_gap(gap);
        chk("gap_sub_3", 16'h0020, 16'(gap));
        wr(INTCTL_ADDR, 16'h0003);
        wr(SUPPLY_ADDR, 16'h0010);
        wr(INTCTL_ADDR, 16'h8001);
        irq_gap(gap);
        chk("gap_osc_1", 16'h0018, 16'(gap));
        wr(INTCTL_ADDR, 16'h0001);
        wr(SUPPLY_ADDR, 16'h0080);
        HALT_I <= 1'b1;
        settle;
        chk("stop_halt", 16'h0001, 16'(PERIPH_STOP_O));
        HALT_I <= 1'b0;
        STOP_I <= 1'b1;
        settle;
        chk("stop_stop", 16'h0001, 16'(PERIPH_STOP_O));
        wr(SUPPLY_ADDR, 16'h0090);
        settle;
        chk("stop_osc", 16'h0000, 16'(PERIPH_STOP_O));
        wr(CLKEN_ADDR, 16'h0000);
        rd(INTCTL_ADDR, 16'h0FFF, "intctl_off");
        chk("rtc_off", 16'h0001, {14'h0000, RTC_CLK_EN_O, RTC_RST_O});
        results;
    end
endmodule
`default_nettype wire
